// File: hdl/rx_status_regs.sv
// receive status, channel a data and validity registers of the radio baseband
// ****************************************
// Summary of operation
// - enable bit 0 gates channel a full irq
// - receiver transfer raises full: byte or eof with a partial byte
// - status bits set regardless of enables
// - status reads zero outside receive mode
// - writes to status register are ignored
// - valid bit set when all byte bits valid
// - load before read sets flow violation
// - reading empty data register sets flow violation
// - status read clears flow and eof bits
// - eof after programmed gap of bit times
// - full pending in bit 4 b, 0 a
// - data a at 0x09, first bit in bit 0
// - validity mask a at 0x0a, read only
// - zero gap length: eof at first invalid bit
// - holding registers used only in byte mode
// ****************************************
`timescale 1ns/100ps
`default_nettype none
module rx_status_regs
  import rx_status_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic RXA_BIT_STB_I,
  input wire logic RXA_BIT_VAL_I,
  input wire logic RXA_BIT_DAT_I,
  input wire logic RXB_BIT_STB_I,
  input wire logic RXB_BIT_VAL_I,
  input wire logic RXB_BIT_DAT_I,
  output logic IRQ_O
);
  logic [7:0] rf_ctrl_r, rf_ctrl_nxt;
  logic [7:0] ser_ctrl_r, ser_ctrl_nxt;
  logic [7:0] irq_en_r, irq_en_nxt;
  logic [7:0] stat_r, stat_nxt;
  logic [7:0] data_a_r, data_a_nxt;
  logic [7:0] mask_a_r, mask_a_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rx_mode;
  logic gather_en;
  logic rd_stat;
  logic rd_data_a;
  logic rd_data_b;
  logic load_a, eof_a, load_b, eof_b;
  logic [7:0] byte_a, valid_a, valid_b;

  // receive only when rx enabled and tx off
  assign rx_mode = rf_ctrl_r[BIT_RX_EN] & ~rf_ctrl_r[BIT_TX_EN];
  assign gather_en = rx_mode & ser_ctrl_r[BIT_SER_SEL];
  assign rd_stat = REG_RD_I && REG_ADDR_I == OFS_RX_STAT;
  assign rd_data_a = REG_RD_I && REG_ADDR_I == OFS_RX_DATA_A;
  assign rd_data_b = REG_RD_I && REG_ADDR_I == OFS_RX_DATA_B;

  // ****************************************
  // channel receivers
  // ****************************************
  rx_byte_gather u_gather_a (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .en_i(gather_en),
    .bit_stb_i(RXA_BIT_STB_I),
    .bit_val_i(RXA_BIT_VAL_I),
    .bit_dat_i(RXA_BIT_DAT_I),
    .eof_len_i(ser_ctrl_r[EOF_LEN_MSB:0]),
    .load_o(load_a),
    .eof_o(eof_a),
    .data_o(byte_a),
    .mask_o(valid_a)
  );

  // channel b data itself is kept outside; only its status lives here
  rx_byte_gather u_gather_b (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .en_i(gather_en),
    .bit_stb_i(RXB_BIT_STB_I),
    .bit_val_i(RXB_BIT_VAL_I),
    .bit_dat_i(RXB_BIT_DAT_I),
    .eof_len_i(ser_ctrl_r[EOF_LEN_MSB:0]),
    .load_o(load_b),
    .eof_o(eof_b),
    .data_o(),
    .mask_o(valid_b)
  );

  // ****************************************
  // status and data next state
  // ****************************************
  always_comb begin
    stat_nxt = stat_r;
    data_a_nxt = data_a_r;
    mask_a_nxt = mask_a_r;
    // clears first, so a same-cycle event wins
    if (rd_stat) begin
      stat_nxt = stat_r & ~READ_CLEARED;
    end
    if (rd_data_a) begin
      if (stat_r[ST_FULL_A]) begin
        stat_nxt[ST_FULL_A] = 1'b0;
      end else begin
        stat_nxt[ST_FLOW_A] = 1'b1;
      end
    end
    if (rd_data_b) begin
      if (stat_r[ST_FULL_B]) begin
        stat_nxt[ST_FULL_B] = 1'b0;
      end else begin
        stat_nxt[ST_FLOW_B] = 1'b1;
      end
    end
    // sets never look at the enables, so polling works
    if (load_a) begin
      if (stat_r[ST_FULL_A] && !rd_data_a) begin
        stat_nxt[ST_FLOW_A] = 1'b1;
      end
      stat_nxt[ST_FULL_A] = 1'b1;
      stat_nxt[ST_VALID_A] = (valid_a == ALL_BITS_VALID);
      data_a_nxt = byte_a;
      mask_a_nxt = valid_a;
    end
    if (load_b) begin
      if (stat_r[ST_FULL_B] && !rd_data_b) begin
        stat_nxt[ST_FLOW_B] = 1'b1;
      end
      stat_nxt[ST_FULL_B] = 1'b1;
      stat_nxt[ST_VALID_B] = (valid_b == ALL_BITS_VALID);
    end
    if (eof_a) begin
      stat_nxt[ST_EOF_A] = 1'b1;
    end
    if (eof_b) begin
      stat_nxt[ST_EOF_B] = 1'b1;
    end
    if (!rx_mode) begin
      stat_nxt = RST_BYTE;
    end
  end

  // ****************************************
  // host port: writes and read data
  // ****************************************
  always_comb begin
    rf_ctrl_nxt = rf_ctrl_r;
    ser_ctrl_nxt = ser_ctrl_r;
    irq_en_nxt = irq_en_r;
    rdata_nxt = rdata_r;
    // status, data and mask take no writes
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        OFS_RF_CTRL: rf_ctrl_nxt = REG_WDATA_I;
        OFS_SER_CTRL: ser_ctrl_nxt = REG_WDATA_I;
        OFS_RX_IRQ_EN: irq_en_nxt = REG_WDATA_I;
        default: rf_ctrl_nxt = rf_ctrl_r;
      endcase
    end
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        OFS_RF_CTRL: rdata_nxt = rf_ctrl_r;
        OFS_SER_CTRL: rdata_nxt = ser_ctrl_r;
        OFS_RX_IRQ_EN: rdata_nxt = irq_en_r;
        OFS_RX_STAT: rdata_nxt = stat_r & {8{rx_mode}};
        OFS_RX_DATA_A: rdata_nxt = data_a_r;
        OFS_RX_MASK_A: rdata_nxt = mask_a_r;
        default: rdata_nxt = RST_BYTE;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      rf_ctrl_r <= RST_BYTE;
      ser_ctrl_r <= RST_BYTE;
      irq_en_r <= RST_BYTE;
      stat_r <= RST_BYTE;
      data_a_r <= RST_BYTE;
      mask_a_r <= RST_BYTE;
      rdata_r <= RST_BYTE;
    end else begin
      rf_ctrl_r <= rf_ctrl_nxt;
      ser_ctrl_r <= ser_ctrl_nxt;
      irq_en_r <= irq_en_nxt;
      stat_r <= stat_nxt;
      data_a_r <= data_a_nxt;
      mask_a_r <= mask_a_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign REG_RDATA_O = rdata_r;
  // valid bits are masked off: they never interrupt
  assign IRQ_O = |(stat_r & irq_en_r & IRQ_CAPABLE);

  // ****************************************
  // checks
  // ****************************************
  chk_full_irq_gate: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    rx_mode && load_a && irq_en_r[0] && !REG_WR_I |=> IRQ_O && stat_r[ST_FULL_A])
    else $error("enabled full a did not raise the interrupt");
  chk_full_on_load: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    rx_mode && load_b && !REG_WR_I |=> stat_r[ST_FULL_B])
    else $error("load did not set full");
  chk_valid_all: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    rx_mode && load_a && !REG_WR_I |=> stat_r[ST_VALID_A] == (mask_a_r == ALL_BITS_VALID))
    else $error("valid a does not match the mask");
  chk_overflow_set: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    rx_mode && load_a && stat_r[ST_FULL_A] && !REG_RD_I && !REG_WR_I |=> stat_r[ST_FLOW_A])
    else $error("overflow a not flagged");
  chk_underflow_set: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    rx_mode && rd_data_a && !stat_r[ST_FULL_A] && !REG_WR_I |=> stat_r[ST_FLOW_A])
    else $error("underflow a not flagged");
  chk_read_clears: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    rd_stat && !eof_a && !load_a |=> !stat_r[ST_EOF_A] && !stat_r[ST_FLOW_A])
    else $error("status read did not clear eof a and flow a");
  chk_idle_zero: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    rd_stat && !rx_mode |=> REG_RDATA_O == RST_BYTE)
    else $error("status not zero outside receive mode");
  chk_wr_ignored: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    REG_WR_I && REG_ADDR_I == OFS_RX_STAT && rx_mode && !load_a && !load_b && !eof_a && !eof_b
    |=> $stable(stat_r))
    else $error("write changed the status register");
  chk_eof_flag: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    rx_mode && eof_b && !REG_WR_I |=> stat_r[ST_EOF_B])
    else $error("eof b not flagged");
  chk_byte_mode_only: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    !gather_en ##1 !gather_en |-> !load_a && !load_b)
    else $error("holding register loaded outside byte mode");
endmodule : rx_status_regs
`default_nettype wire

// File: hdl/rx_status_pkg.sv
// constants for the receive status and data register bank
package rx_status_pkg;
  // register offsets
  localparam logic [7:0] OFS_RF_CTRL = 8'h03;
  localparam logic [7:0] OFS_SER_CTRL = 8'h06;
  localparam logic [7:0] OFS_RX_IRQ_EN = 8'h07;
  localparam logic [7:0] OFS_RX_STAT = 8'h08;
  localparam logic [7:0] OFS_RX_DATA_A = 8'h09;
  localparam logic [7:0] OFS_RX_MASK_A = 8'h0a;
  localparam logic [7:0] OFS_RX_DATA_B = 8'h0b;
  // field positions
  localparam int unsigned BIT_TX_EN = 7;
  localparam int unsigned BIT_RX_EN = 6;
  localparam int unsigned BIT_SER_SEL = 3;
  localparam int unsigned EOF_LEN_MSB = 2;
  localparam int unsigned ST_FULL_A = 0;
  localparam int unsigned ST_EOF_A = 1;
  localparam int unsigned ST_FLOW_A = 2;
  localparam int unsigned ST_VALID_A = 3;
  localparam int unsigned ST_FULL_B = 4;
  localparam int unsigned ST_EOF_B = 5;
  localparam int unsigned ST_FLOW_B = 6;
  localparam int unsigned ST_VALID_B = 7;
  // status bits able to interrupt (valid bits never do)
  localparam logic [7:0] IRQ_CAPABLE = 8'h77;
  // status bits cleared by a status read
  localparam logic [7:0] READ_CLEARED = 8'h66;
  localparam logic [7:0] ALL_BITS_VALID = 8'hff;
  // reset values and the last bit index
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_CNT = 4'h0;
  localparam logic [3:0] LAST_BIT = 4'h7;
endpackage : rx_status_pkg

// File: hdl/rx_byte_gather.sv
// one receive channel: packs bit times into a byte with a validity mask
`timescale 1ns/100ps
`default_nettype none
module rx_byte_gather
  import rx_status_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic bit_stb_i,
  input wire logic bit_val_i,
  input wire logic bit_dat_i,
  input wire logic [2:0] eof_len_i,
  output logic load_o,
  output logic eof_o,
  output logic [7:0] data_o,
  output logic [7:0] mask_o
);
  typedef enum logic {IDLE, RECV} gather_e;

  gather_e state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [3:0] gap_r, gap_nxt;
  logic [7:0] shf_r, shf_nxt;
  logic [7:0] msk_r, msk_nxt;
  logic [7:0] data_r, data_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic load_r, load_nxt;
  logic eof_r, eof_nxt;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    gap_nxt = gap_r;
    shf_nxt = shf_r;
    msk_nxt = msk_r;
    data_nxt = data_r;
    mask_nxt = mask_r;
    load_nxt = 1'b0;
    eof_nxt = 1'b0;
    if (!en_i) begin
      state_nxt = IDLE;
      cnt_nxt = RST_CNT;
      gap_nxt = RST_CNT;
      shf_nxt = RST_BYTE;
      msk_nxt = RST_BYTE;
    end else if (bit_stb_i && (bit_val_i || state_r == RECV)) begin
      if (!bit_val_i && ({1'b0, eof_len_i} < gap_r + 4'h1)) begin
        // gap exceeded: end of frame, flush any partial byte
        eof_nxt = 1'b1;
        load_nxt = (cnt_r != RST_CNT);
        data_nxt = shf_r;
        mask_nxt = msk_r;
        state_nxt = IDLE;
        cnt_nxt = RST_CNT;
        gap_nxt = RST_CNT;
        shf_nxt = RST_BYTE;
        msk_nxt = RST_BYTE;
      end else begin
        // first bit over the air lands in bit 0
        shf_nxt[cnt_r[2:0]] = bit_val_i & bit_dat_i;
        msk_nxt[cnt_r[2:0]] = bit_val_i;
        gap_nxt = bit_val_i ? RST_CNT : gap_r + 4'h1;
        state_nxt = RECV;
        if (cnt_r == LAST_BIT) begin
          load_nxt = 1'b1;
          data_nxt = shf_nxt;
          mask_nxt = msk_nxt;
          cnt_nxt = RST_CNT;
          shf_nxt = RST_BYTE;
          msk_nxt = RST_BYTE;
        end else begin
          cnt_nxt = cnt_r + 4'h1;
        end
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= IDLE;
      cnt_r <= RST_CNT;
      gap_r <= RST_CNT;
      shf_r <= RST_BYTE;
      msk_r <= RST_BYTE;
      data_r <= RST_BYTE;
      mask_r <= RST_BYTE;
      load_r <= 1'b0;
      eof_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      gap_r <= gap_nxt;
      shf_r <= shf_nxt;
      msk_r <= msk_nxt;
      data_r <= data_nxt;
      mask_r <= mask_nxt;
      load_r <= load_nxt;
      eof_r <= eof_nxt;
    end
  end

  assign load_o = load_r;
  assign eof_o = eof_r;
  assign data_o = data_r;
  assign mask_o = mask_r;

  chk_eof_zero_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && bit_stb_i && !bit_val_i && state_r == RECV && eof_len_i == 3'h0 |=> eof_o)
    else $error("zero gap length did not end the frame");
endmodule : rx_byte_gather
`default_nettype wire

// File: tb/rx_host_model.sv
// host side model of the register port
`timescale 1ns/100ps
`default_nettype none
module rx_host_model (
  input wire logic clk_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // ****************************************
  // one access per call
  // ****************************************
  // released address and data lines are inverted so stale values never pass for held ones
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : access
endmodule : rx_host_model
`default_nettype wire

// File: tb/rx_serdes_status_data_tb_top.sv
// self-checking bench of the receive status and data registers
`timescale 1ns/100ps
`default_nettype none
module rx_serdes_status_data_tb_top;
  import rx_status_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr, wdata, rdata, d1, d2, d3, d4;
  logic wr, rd, irq, rd_d, stb_a, stb_b, val, dat;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] exp_q[$];
  always #2.5 clk_sys = ~clk_sys;
  rx_status_regs dut (.CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .REG_ADDR_I(addr),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .RXA_BIT_STB_I(stb_a), .RXA_BIT_VAL_I(val), .RXA_BIT_DAT_I(dat),
    .RXB_BIT_STB_I(stb_b), .RXB_BIT_VAL_I(val), .RXB_BIT_DAT_I(dat), .IRQ_O(irq));
  rx_host_model host (.clk_i(clk_sys), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  // ****************************************
  // compares and drivers
  // ****************************************
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp8
  task automatic cmp1(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp1
  task automatic irq_is(input logic e);
    @(negedge clk_sys);
    cmp1(irq, e);
  endtask : irq_is
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.access(1'b0, a, 8'h00);
  endtask : rd_chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d);
  endtask : wr_reg
  // ch bit 0 feeds channel a, bit 1 channel b; waits for status to settle
  task automatic send(input logic [1:0] ch, input logic [7:0] d, input logic [7:0] v,
                      input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      stb_a <= ch[0];
      stb_b <= ch[1];
      val <= v[i];
      dat <= d[i];
      @(posedge clk_sys);
      stb_a <= 1'b0;
      stb_b <= 1'b0;
      val <= ~v[i];
      dat <= ~d[i];
    end
    repeat (3) @(posedge clk_sys);
  endtask : send
  task automatic end_sim();
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  // ****************************************
  // result watcher and timeout
  // ****************************************
  always @(posedge clk_sys) begin
    rd_d <= rd;
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      end_sim();
    end
  end
  always @(negedge clk_sys) begin
    if (rd_d === 1'b1) begin
      cmp8(rdata, exp_q.pop_front());
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    stb_a = 1'b0;
    stb_b = 1'b0;
    val = 1'b0;
    dat = 1'b0;
    rd_d = 1'b0;
    void'($urandom(49973));
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    d3 = 8'($urandom);
    d4 = 8'($urandom);
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(OFS_RX_STAT, 8'h00);
    rd_chk(OFS_RX_DATA_A, 8'h00);
    rd_chk(OFS_RX_MASK_A, 8'h00);
    wr_reg(8'h20, 8'hff);
    rd_chk(8'h20, 8'h00);
    wr_reg(OFS_RF_CTRL, 8'h40);
    wr_reg(OFS_SER_CTRL, 8'h0f);
    wr_reg(OFS_RX_IRQ_EN, 8'h01);
    rd_chk(OFS_SER_CTRL, 8'h0f);
    send(2'b11, d1, 8'hff, 8);
    irq_is(1'b1);
    rd_chk(OFS_RX_STAT, 8'h99);
    wr_reg(OFS_RX_STAT, 8'hff);
    rd_chk(OFS_RX_STAT, 8'h99);
    rd_chk(OFS_RX_MASK_A, 8'hff);
    rd_chk(OFS_RX_DATA_A, d1);
    rd_chk(OFS_RX_DATA_B, 8'h00);
    irq_is(1'b0);
    rd_chk(OFS_RX_DATA_B, 8'h00);
    rd_chk(OFS_RX_STAT, 8'hc8);
    rd_chk(OFS_RX_STAT, 8'h88);
    send(2'b11, d2, 8'hff, 8);
    send(2'b11, d3, 8'hff, 8);
    rd_chk(OFS_RX_STAT, 8'hdd);
    rd_chk(OFS_RX_DATA_A, d3);
    rd_chk(OFS_RX_DATA_B, 8'h00);
    // seven invalid bits stay within the gap and take positions 0 to 6
    send(2'b11, 8'h00, 8'h00, 7);
    rd_chk(OFS_RX_STAT, 8'h88);
    // eighth one ends the frame and flushes the all-invalid partial byte
    send(2'b11, 8'h00, 8'h00, 1);
    rd_chk(OFS_RX_STAT, 8'h33);
    rd_chk(OFS_RX_STAT, 8'h11);
    rd_chk(OFS_RX_MASK_A, 8'h00);
    rd_chk(OFS_RX_DATA_A, 8'h00);
    rd_chk(OFS_RX_DATA_B, 8'h00);
    wr_reg(OFS_SER_CTRL, 8'h08);
    wr_reg(OFS_RX_IRQ_EN, 8'h02);
    send(2'b01, d4, 8'h07, 3);
    send(2'b01, 8'h00, 8'h00, 1);
    irq_is(1'b1);
    rd_chk(OFS_RX_STAT, 8'h03);
    irq_is(1'b0);
    rd_chk(OFS_RX_MASK_A, 8'h07);
    rd_chk(OFS_RX_DATA_A, d4 & 8'h07);
    // holding register a is empty now: a second read is an underflow
    rd_chk(OFS_RX_DATA_A, d4 & 8'h07);
    rd_chk(OFS_RX_STAT, 8'h04);
    send(2'b01, d1, 8'hff, 8);
    wr_reg(OFS_RF_CTRL, 8'hc0);
    rd_chk(OFS_RX_STAT, 8'h00);
    wr_reg(OFS_RF_CTRL, 8'h40);
    rd_chk(OFS_RX_STAT, 8'h00);
    wr_reg(OFS_SER_CTRL, 8'h07);
    send(2'b01, d2, 8'hff, 8);
    rd_chk(OFS_RX_STAT, 8'h00);
    repeat (4) @(posedge clk_sys);
    end_sim();
  end
endmodule : rx_serdes_status_data_tb_top
`default_nettype wire
